// [verilog/gsc_pkg.sv]
// Constants, types and CRC function for the gas sensor command port
package gsc_pkg;
    localparam int CLK_MHZ        = 20;
    localparam int MEAS_TIME_US   = 30000;
    localparam int TEST_TIME_US   = 320000;
    localparam int UID_TIME_US    = 1000;
    localparam int PU_TIME_US     = 600;
    localparam int MEAS_CYC       = MEAS_TIME_US * CLK_MHZ;
    localparam int TEST_CYC       = TEST_TIME_US * CLK_MHZ;
    localparam int UID_CYC        = UID_TIME_US * CLK_MHZ;
    localparam int PU_CYC         = PU_TIME_US * CLK_MHZ;
    localparam int TMR_W          = 23;

    localparam logic [6:0]  I2C_ADDR       = 7'h59;
    localparam logic [15:0] CMD_MEASURE    = 16'h260f;
    localparam logic [15:0] CMD_SELF_TEST  = 16'h280e;
    localparam logic [15:0] CMD_HEATER_OFF = 16'h3615;
    localparam logic [15:0] CMD_READ_UID   = 16'h3682;
    localparam logic [15:0] DEF_RH         = 16'h8000;
    localparam logic [15:0] DEF_TEMP       = 16'h6666;
    localparam logic [7:0]  CRC_POLY       = 8'h31;
    localparam logic [7:0]  CRC_INIT       = 8'hff;
    localparam logic [7:0]  CRC_XOR        = 8'h00;
    localparam logic [7:0]  TEST_PASS      = 8'hd4;
    localparam logic [7:0]  TEST_FAIL      = 8'h4b;
    localparam logic [7:0]  TEST_LOW       = 8'h00;
    localparam logic [7:0]  PAD_BYTE       = 8'hff;
    localparam logic [3:0]  LEN_CMD        = 4'h2;
    localparam logic [3:0]  LEN_PARAM      = 4'h8;
    localparam logic [3:0]  LEN_WORD       = 4'h3;
    localparam logic [3:0]  LEN_UID        = 4'h9;
    // Arbitrary serial number value
    localparam logic [47:0] UID_DEFAULT    = 48'h0123_4567_89ab;

    typedef enum logic [6:0] {
        L_IDLE = 7'b0000001,
        L_ADDR = 7'b0000010,
        L_AACK = 7'b0000100,
        L_WR   = 7'b0001000,
        L_WACK = 7'b0010000,
        L_RD   = 7'b0100000,
        L_RACK = 7'b1000000
    } gsc_link_e;

    typedef enum logic [4:0] {
        C_PU    = 5'b00001,
        C_READY = 5'b00010,
        C_MEAS  = 5'b00100,
        C_TEST  = 5'b01000,
        C_UID   = 5'b10000
    } gsc_core_e;

    typedef struct packed {
        logic [3:0]  nbytes;
        logic [15:0] code;
        logic [15:0] rh;
        logic [7:0]  rh_crc;
        logic [15:0] temp;
        logic [7:0]  temp_crc;
    } gsc_cmd_s;

    typedef struct packed {
        logic [3:0]  len;
        logic [47:0] words;
    } gsc_resp_s;

    function automatic logic [7:0] gsc_crc8(input logic [15:0] d);
        logic [7:0] c;
        logic       fb;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return c ^ CRC_XOR;
    endfunction
endpackage

// [verilog/gsc_cmd_port.sv]
// I2C target command engine of the gas sensor
`timescale 1ns/1ns

module gsc_cmd_port #(
    parameter int MEAS_CYCLES = gsc_pkg::MEAS_CYC,
    parameter int TEST_CYCLES = gsc_pkg::TEST_CYC,
    parameter int UID_CYCLES  = gsc_pkg::UID_CYC,
    parameter int PU_CYCLES   = gsc_pkg::PU_CYC
) (
    // System
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // I2C link
    input  wire logic        i_link_clk,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe_n,
    // Sensing element
    input  wire logic [15:0] i_raw_gas_ticks,
    input  wire logic        i_self_test_pass,
    output logic             o_heater_on,
    output logic             o_comp_en,
    output logic             o_conv_start,
    output logic             o_test_start,
    output logic [15:0]      o_rh,
    output logic [15:0]      o_temp
);
    import gsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Link domain

    logic             scl_s1, scl_s2, scl_d;
    logic             sda_s1, sda_s2, sda_d;
    logic             busy_s1, busy_s2;
    logic             rdy_s1, rdy_s2, rdy_d;
    gsc_link_e        lst;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic             rw;
    logic [7:0]       wbuf [0:7];
    logic [3:0]       widx;
    logic [3:0]       ridx;
    logic [3:0]       cmd_len;
    logic             wr_act;
    logic             rd_act;
    logic             avail;
    logic             ack_ok;
    logic             cmd_tgl;
    logic [3:0]       len_l;
    logic [47:0]      words_l;
    logic [7:0]       tx_byte;
    logic [15:0]      tx_word;
    logic             start, stop, rise, fall;
    gsc_cmd_s         cmd;
    logic             busy;
    logic             rdy_tgl;
    gsc_resp_s        resp;

    // Oversampled SCL and SDA
    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else begin
            scl_s1 <= i_scl;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= i_sda;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // Busy level and result toggle from core
    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_s1 <= 1'b1;
            busy_s2 <= 1'b1;
            rdy_s1  <= 1'b0;
            rdy_s2  <= 1'b0;
            rdy_d   <= 1'b0;
        end else begin
            busy_s1 <= busy;
            busy_s2 <= busy_s1;
            rdy_s1  <= rdy_tgl;
            rdy_s2  <= rdy_s1;
            rdy_d   <= rdy_s2;
        end
    end

    assign start = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop  = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign rise  = scl_s2 & ~scl_d;
    assign fall  = ~scl_s2 & scl_d;

    // Byte to send: hi, lo, CRC per word, ones beyond the end
    always_comb begin
        case (ridx)
            4'h0, 4'h1, 4'h2: tx_word = words_l[47:32];
            4'h3, 4'h4, 4'h5: tx_word = words_l[31:16];
            default:          tx_word = words_l[15:0];
        endcase
        if (!avail || ridx >= len_l) begin
            tx_byte = PAD_BYTE;
        end else begin
            case (ridx)
                4'h0, 4'h3, 4'h6: tx_byte = tx_word[15:8];
                4'h1, 4'h4, 4'h7: tx_byte = tx_word[7:0];
                default:          tx_byte = gsc_crc8(tx_word);
            endcase
        end
    end

    // Received bytes in order: code, humidity word, temperature word
    assign cmd = {cmd_len, wbuf[0], wbuf[1], wbuf[2], wbuf[3], wbuf[4], wbuf[5],
                  wbuf[6], wbuf[7]};

    // Target protocol engine
    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lst        <= L_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            rw         <= 1'b0;
            widx       <= 4'h0;
            ridx       <= 4'h0;
            cmd_len    <= 4'h0;
            wr_act     <= 1'b0;
            rd_act     <= 1'b0;
            avail      <= 1'b0;
            ack_ok     <= 1'b0;
            cmd_tgl    <= 1'b0;
            o_sda_oe_n <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                wbuf[i] <= 8'h00;
            end
        end else begin
        if (start || stop) begin
            if (wr_act && widx >= LEN_CMD) begin
                cmd_len <= widx;
                cmd_tgl <= ~cmd_tgl;
            end
            if (rd_act) begin
                avail <= 1'b0;
            end
            wr_act     <= 1'b0;
            rd_act     <= 1'b0;
            o_sda_oe_n <= 1'b1;
            bitcnt     <= 4'h0;
            lst        <= start ? L_ADDR : L_IDLE;
            ridx       <= 4'h0;
        end else begin
            if (rise) begin
                case (lst)
                    L_ADDR, L_WR: begin
                        shreg  <= {shreg[6:0], sda_s2};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    L_RACK: ack_ok <= ~sda_s2;
                    default: ;
                endcase
            end
            if (fall) begin
                case (lst)
                    L_ADDR: if (bitcnt == 4'h8) begin
                        if (shreg[7:1] == I2C_ADDR && !busy_s2) begin
                            o_sda_oe_n <= 1'b0;
                            rw         <= shreg[0];
                            lst        <= L_AACK;
                        end else begin
                            lst <= L_IDLE;
                        end
                    end
                    L_AACK: if (rw) begin
                        rd_act     <= 1'b1;
                        ridx       <= 4'h0;
                        o_sda_oe_n <= tx_byte[7];
                        bitcnt     <= 4'h1;
                        lst        <= L_RD;
                    end else begin
                        wr_act     <= 1'b1;
                        widx       <= 4'h0;
                        o_sda_oe_n <= 1'b1;
                        bitcnt     <= 4'h0;
                        lst        <= L_WR;
                    end
                    L_WR: if (bitcnt == 4'h8) begin
                        if (widx < LEN_PARAM) begin
                            wbuf[widx[2:0]] <= shreg;
                            widx            <= widx + 4'h1;
                            o_sda_oe_n      <= 1'b0;
                            lst             <= L_WACK;
                        end else begin
                            lst <= L_IDLE;
                        end
                    end
                    L_WACK: begin
                        o_sda_oe_n <= 1'b1;
                        bitcnt     <= 4'h0;
                        lst        <= L_WR;
                    end
                    L_RD: if (bitcnt == 4'h8) begin
                        o_sda_oe_n <= 1'b1;
                        ridx       <= ridx + 4'h1;
                        lst        <= L_RACK;
                    end else begin
                        o_sda_oe_n <= tx_byte[3'h7 - bitcnt[2:0]];
                        bitcnt     <= bitcnt + 4'h1;
                    end
                    L_RACK: if (ack_ok) begin
                        o_sda_oe_n <= tx_byte[7];
                        bitcnt     <= 4'h1;
                        lst        <= L_RD;
                    end else begin
                        lst <= L_IDLE;
                    end
                    default: ;
                endcase
            end
        end
        if (rdy_s2 ^ rdy_d) begin
            avail <= 1'b1;
        end
        end
    end

    // Result copy, stable while core is idle
    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            len_l   <= 4'h0;
            words_l <= 48'h0;
        end else if (rdy_s2 ^ rdy_d) begin
            len_l   <= resp.len;
            words_l <= resp.words;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sda <= 1'b0;
        end else begin
            o_sda <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain

    logic             c_s1, c_s2, c_d;
    logic             cmd_ev;
    gsc_core_e        cst;
    logic [TMR_W-1:0] timer;
    logic             meas_mode;
    logic             par_ok;
    logic             meas_ok;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            c_s1 <= 1'b0;
            c_s2 <= 1'b0;
            c_d  <= 1'b0;
        end else begin
            c_s1 <= cmd_tgl;
            c_s2 <= c_s1;
            c_d  <= c_s2;
        end
    end

    assign cmd_ev  = c_s2 ^ c_d;
    assign par_ok  = gsc_crc8(cmd.rh) == cmd.rh_crc && gsc_crc8(cmd.temp) == cmd.temp_crc;
    assign meas_ok = cmd.code == CMD_MEASURE && cmd.nbytes == LEN_PARAM && par_ok;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cst          <= C_PU;
            timer        <= TMR_W'(PU_CYCLES - 1);
            meas_mode    <= 1'b0;
            busy         <= 1'b1;
            rdy_tgl      <= 1'b0;
            resp         <= '0;
            o_heater_on  <= 1'b0;
            o_comp_en    <= 1'b0;
            o_conv_start <= 1'b0;
            o_test_start <= 1'b0;
            o_rh         <= DEF_RH;
            o_temp       <= DEF_TEMP;
        end else begin
            o_conv_start <= 1'b0;
            o_test_start <= 1'b0;
            busy         <= cst != C_READY;
            case (cst)
                C_PU: if (timer == '0) begin
                    cst <= C_READY;
                end else begin
                    timer <= timer - 1'b1;
                end
                C_READY: if (cmd_ev) begin
                    if (meas_ok) begin
                        cst          <= C_MEAS;
                        timer        <= TMR_W'(MEAS_CYCLES - 1);
                        meas_mode    <= 1'b1;
                        o_heater_on  <= 1'b1;
                        o_conv_start <= 1'b1;
                        o_rh         <= cmd.rh;
                        o_temp       <= cmd.temp;
                        o_comp_en    <= !(cmd.rh == DEF_RH && cmd.temp == DEF_TEMP);
                    end else if (cmd.code == CMD_SELF_TEST && cmd.nbytes == LEN_CMD) begin
                        cst          <= C_TEST;
                        timer        <= TMR_W'(TEST_CYCLES - 1);
                        o_heater_on  <= 1'b1;
                        o_test_start <= 1'b1;
                    end else if (cmd.code == CMD_HEATER_OFF && cmd.nbytes == LEN_CMD) begin
                        meas_mode   <= 1'b0;
                        o_heater_on <= 1'b0;
                    end else if (cmd.code == CMD_READ_UID && cmd.nbytes == LEN_CMD
                                 && !meas_mode) begin
                        cst   <= C_UID;
                        timer <= TMR_W'(UID_CYCLES - 1);
                    end
                end
                C_MEAS, C_TEST, C_UID: if (timer == '0) begin
                    cst     <= C_READY;
                    rdy_tgl <= ~rdy_tgl;
                    if (cst == C_MEAS) begin
                        resp <= {LEN_WORD, i_raw_gas_ticks, 32'h0};
                    end else if (cst == C_TEST) begin
                        resp <= {LEN_WORD, i_self_test_pass ? TEST_PASS : TEST_FAIL,
                                 TEST_LOW, 32'h0};
                        o_heater_on <= meas_mode;
                    end else begin
                        resp <= {LEN_UID, UID_DEFAULT};
                    end
                end else begin
                    timer <= timer - 1'b1;
                end
                default: cst <= C_READY;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_meas_start;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_READY && cmd_ev && meas_ok) |=> (o_conv_start && o_heater_on && cst == C_MEAS);
    endproperty
    a_meas_start: assert property (p_meas_start) else $error("measure not started");

    property p_meas_done;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_MEAS && timer == '0) |=>
            (resp.len == LEN_WORD && resp.words[47:32] == $past(i_raw_gas_ticks));
    endproperty
    a_meas_done: assert property (p_meas_done) else $error("raw word wrong");

    property p_heater_off;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_READY && cmd_ev && cmd.code == CMD_HEATER_OFF && cmd.nbytes == LEN_CMD)
            |=> (!o_heater_on && !meas_mode);
    endproperty
    a_heater_off: assert property (p_heater_off) else $error("heater still on");

    property p_comp;
        @(posedge i_clk) disable iff (!i_nrst)
        o_conv_start |-> (o_comp_en != (o_rh == DEF_RH && o_temp == DEF_TEMP));
    endproperty
    a_comp: assert property (p_comp) else $error("compensation wrong");

    property p_test_idle;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_TEST && timer == '0 && !meas_mode) |=> (!o_heater_on && cst == C_READY);
    endproperty
    a_test_idle: assert property (p_test_idle) else $error("heater on after test");

    property p_test_meas;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_TEST && timer == '0 && meas_mode) |=> o_heater_on;
    endproperty
    a_test_meas: assert property (p_test_meas) else $error("heater off after test");

    property p_test_word;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_TEST && timer == '0) |=>
            resp.words[47:40] == ($past(i_self_test_pass) ? TEST_PASS : TEST_FAIL);
    endproperty
    a_test_word: assert property (p_test_word) else $error("test word wrong");

    property p_uid;
        @(posedge i_clk) disable iff (!i_nrst)
        (cst == C_UID && timer == '0) |=> (resp.len == LEN_UID && $changed(rdy_tgl));
    endproperty
    a_uid: assert property (p_uid) else $error("serial not ready");

    property p_busy_nack;
        @(posedge i_link_clk) disable iff (!i_nrst)
        (lst == L_ADDR && fall && bitcnt == 4'h8 && busy_s2 && !start && !stop)
            |=> (lst == L_IDLE && o_sda_oe_n);
    endproperty
    a_busy_nack: assert property (p_busy_nack) else $error("busy access acked");

    property p_no_ack_stop;
        @(posedge i_link_clk) disable iff (!i_nrst)
        (lst == L_RACK && fall && !ack_ok && !start && !stop) |=> (lst == L_IDLE && o_sda_oe_n);
    endproperty
    a_no_ack_stop: assert property (p_no_ack_stop) else $error("sent after nack");
endmodule

// [bench/gsc_i2c_master.sv]
// I2C bus master model for the gas sensor bench
`timescale 1ns/1ns
module gsc_i2c_master (
    // Bus
    output logic      o_scl,
    output logic      o_sda,
    input  wire logic i_sda
);
    localparam int Q = 800;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic clk_bit(input logic b, output logic r);
        o_sda = b;
        #Q;
        o_scl = 1'b1;
        #Q;
        r = i_sda;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic start();
        o_sda = 1'b1;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda = 1'b0;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda = 1'b1;
        #Q;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, d[i]);
        end
        clk_bit(last, r);
    endtask
endmodule

// [bench/tb_gas_sensor_i2c_command_port.sv]
// Self-checking bench of the gas sensor command port
`timescale 1ns/1ns
module tb_gas_sensor_i2c_command_port;
    import gsc_pkg::*;
    logic        clk = 1'b0;
    logic        lclk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] raw = 16'h0000;
    logic        pass = 1'b0;
    logic        scl, msda, sda_o, oe_n, heat, comp, conv, tst, ack;
    logic [15:0] rh, tmp, h, t, ph, pt;
    logic [7:0]  q [9];
    wire         sda = msda & (oe_n | sda_o);
    int          error_cnt = 0;
    int          comparisons = 0;
    int          convs = 0;
    int          tests = 0;
    int          c;
    always #25 clk = ~clk;
    initial #13 forever #80 lclk = ~lclk;
    always_ff @(posedge clk) begin
        convs <= convs + int'(conv);
        tests <= tests + int'(tst);
    end
    gsc_i2c_master m (.o_scl(scl), .o_sda(msda), .i_sda(sda));
    gsc_cmd_port #(.MEAS_CYCLES(2000), .TEST_CYCLES(4000), .UID_CYCLES(1000), .PU_CYCLES(20)) uut (
        .i_clk(clk), .i_nrst(nrst), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
        .o_sda(sda_o), .o_sda_oe_n(oe_n), .i_raw_gas_ticks(raw), .i_self_test_pass(pass),
        .o_heater_on(heat), .o_comp_en(comp), .o_conv_start(conv), .o_test_start(tst),
        .o_rh(rh), .o_temp(tmp));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] crc(input logic [15:0] d);
        logic [7:0] x;
        x = 8'hff;
        for (int i = 15; i >= 0; i--) begin
            x = (x[7] ^ d[i]) ? {x[6:0], 1'b0} ^ 8'h31 : {x[6:0], 1'b0};
        end
        return x;
    endfunction
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cmd(input logic [63:0] v, input int n);
        m.start();
        m.wbyte(8'hb2, ack);
        chk("write header ack", 16'(ack), 16'h0001);
        for (int k = n - 1; k >= 0; k--) begin
            m.wbyte(v[8*k+:8], ack);
        end
        m.stop();
        repeat (10) @(posedge clk);
    endtask
    task automatic hdr(input logic [7:0] a, output logic k);
        m.start();
        m.wbyte(a, k);
        m.stop();
    endtask
    task automatic rd(input int n, input int tries);
        ack = 1'b0;
        for (int i = 0; i < tries && !ack; i++) begin
            m.start();
            m.wbyte(8'hb3, ack);
            if (!ack) m.stop();
        end
        chk("read header ack", 16'(ack), 16'h0001);
        for (int k = 0; k < n; k++) begin
            m.rbyte(k == n - 1, q[k]);
        end
        m.stop();
    endtask
    task automatic cw(input int k, input logic [15:0] e);
        chk("word", {q[k], q[k+1]}, e);
        chk("word crc", 16'(q[k+2]), 16'(crc(e)));
    endtask
    task automatic ones(input int n);
        for (int k = 0; k < n; k++) chk("pad", 16'(q[k]), 16'h00ff);
    endtask
    task automatic results();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #4_500_000;
        error_cnt++;
        results();
    end
    initial begin
        void'($urandom(32'h1ba1e9f6));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (60) @(posedge clk);
        chk("crc ref", 16'(crc(16'hbeef)), 16'h0092);
        rd(3, 1);
        ones(3);
        hdr(8'hb4, ack);
        chk("foreign address", 16'(ack), 16'h0000);
        // Default, compensated, then corrupted parameters
        for (int i = 0; i < 3; i++) begin
            h = (i == 0) ? DEF_RH : 16'($urandom);
            t = (i == 0) ? DEF_TEMP : 16'($urandom);
            c = convs;
            @(posedge clk);
            raw <= 16'($urandom);
            cmd({16'h260f, h, crc(h) ^ 8'(i == 2), t, crc(t)}, 8);
            chk("heater", 16'(heat), 16'h0001);
            chk("comp", 16'(comp), 16'(i != 0));
            chk("conv", 16'(convs - c), 16'(i != 2));
            chk("rh", rh, (i == 2) ? ph : h);
            chk("temp", tmp, (i == 2) ? pt : t);
            if (i < 2) begin
                ph = h;
                pt = t;
                hdr(8'hb3, ack);
                chk("busy nack", 16'(ack), 16'h0000);
                rd(3, 20);
                cw(0, raw);
                rd(3, 1);
                ones(3);
            end
        end
        // Self-test in measurement mode, then from idle
        for (int j = 0; j < 2; j++) begin
            if (j == 1) cmd(64'h3615, 2);
            chk("heater before test", 16'(heat), 16'(j == 0));
            @(posedge clk);
            pass <= (j == 0);
            c = tests;
            cmd(64'h280e, 2);
            chk("test start", 16'(tests - c), 16'h0001);
            hdr(8'hb3, ack);
            chk("test busy nack", 16'(ack), 16'h0000);
            rd(3, 60);
            cw(0, {(j == 0) ? TEST_PASS : TEST_FAIL, TEST_LOW});
            chk("heater after test", 16'(heat), 16'(j == 0));
        end
        cmd(64'h1234, 2);
        chk("unknown code", 16'(heat), 16'h0000);
        cmd(64'h3682, 2);
        rd(9, 20);
        for (int k = 0; k < 3; k++) cw(3 * k, UID_DEFAULT[47-16*k-:16]);
        results();
    end
endmodule
